// ---- lmt_pkg.sv ----
// Constants for the light measurement timing block
// Operation
// - Step length is eleven bits over two registers
// - Each step lasts step plus one divided modulator clocks
// - Step low byte resets to 0xB3
// - Divider selection above zero lengthens every modulator step
// - Integration is count plus one steps
// - Flicker step takes count plus one samples
// - Endless bit repeats flicker without end markers
// - Wait equals trigger setting times wait value
// - Low threshold compared with selected channel data
// - Persistent below-low data raises interrupt and low flag
// - Counts, wait, thresholds reset to zero
// - Persistent above-high data raises interrupt and flag
// - Writing one clears flag and pending interrupts
// - Power off halts and clears all timing
package lmt_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] LMT_ADDR_STEP_LO = 8'h83;
  localparam logic [7:0] LMT_ADDR_STEP_HI = 8'h84;
  localparam logic [7:0] LMT_ADDR_ALS_LO = 8'h85;
  localparam logic [7:0] LMT_ADDR_ALS_HI = 8'h86;
  localparam logic [7:0] LMT_ADDR_FD_LO = 8'h87;
  localparam logic [7:0] LMT_ADDR_FD_HI = 8'h88;
  localparam logic [7:0] LMT_ADDR_WAIT = 8'h89;
  localparam logic [7:0] LMT_ADDR_LOW_TH0 = 8'h8A;
  localparam logic [7:0] LMT_ADDR_LOW_TH1 = 8'h8B;
  localparam logic [7:0] LMT_ADDR_LOW_TH2 = 8'h8C;
  localparam logic [7:0] LMT_ADDR_HIGH_TH0 = 8'h8D;
  localparam logic [7:0] LMT_ADDR_HIGH_TH1 = 8'h8E;
  localparam logic [7:0] LMT_ADDR_HIGH_TH2 = 8'h8F;
  localparam logic [7:0] LMT_ADDR_STATUS = 8'h93;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int LMT_HI_FIELD_W = 3;
  localparam int LMT_ENDLESS_BIT = 7;
  localparam int LMT_IRQ_FLAG_BIT = 3;
  localparam logic [10:0] LMT_STEP_RESET = 11'h0B3;
  // ****************************************
  // Timing
  // ****************************************
  localparam longint LMT_MOD_PERIOD_FS = 1388889000;
  localparam longint LMT_CLK_PERIOD_FS = 5000000;
  localparam int LMT_MOD_CYCLES = int'(LMT_MOD_PERIOD_FS / LMT_CLK_PERIOD_FS);
  typedef enum logic [1:0] {LMT_IDLE, LMT_MEASURE, LMT_WAIT} lmt_state_t;
endpackage

// ---- lmt_timing.sv ----
// Light measurement timing, thresholds and interrupt flag
`timescale 1ns/10ps
`default_nettype none
module lmt_timing #(
  parameter int MOD_CYCLES = lmt_pkg::LMT_MOD_CYCLES,
  parameter int DIV_SEL_W = 3,
  parameter int PERS_W = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_power_on_bit,
  input wire logic i_light_enable,
  input wire logic i_flicker_enable,
  input wire logic [DIV_SEL_W-1:0] i_modulator_clock_divider,
  input wire logic [7:0] i_trigger_timing_setting,
  input wire logic i_light_interrupt_enable,
  input wire logic [PERS_W-1:0] i_persistence_count,
  input wire logic i_threshold_channel_select,
  input wire logic i_accum_valid,
  input wire logic [23:0] i_accum_data0,
  input wire logic [23:0] i_accum_data1,
  output logic o_sample_tick,
  output logic o_light_done,
  output logic o_flicker_step_done,
  output logic o_flicker_end_marker,
  output logic o_measuring,
  output logic o_light_irq,
  output logic o_low_threshold_flag,
  output logic o_high_threshold_flag
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  if (MOD_CYCLES < 1 || MOD_CYCLES > 65535) begin : g_bad_mod
    $error("MOD_CYCLES out of range");
  end
  if (DIV_SEL_W < 1 || DIV_SEL_W > 4) begin : g_bad_div
    $error("DIV_SEL_W out of range");
  end

  localparam int DIV_W = 1 << DIV_SEL_W;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [10:0] step;
    logic [10:0] als_cnt;
    logic [10:0] fd_cnt;
    logic endless;
    logic [7:0] wait_val;
    logic [23:0] low_th;
    logic [23:0] high_th;
    logic [10:0] sh_step;
    logic [10:0] sh_als;
    logic [10:0] sh_fd;
    logic sh_endless;
    logic [15:0] sh_wait;
    lmt_pkg::lmt_state_t state;
    logic [15:0] pre;
    logic [DIV_W-1:0] div;
    logic [10:0] step_idx;
    logic [10:0] als_idx;
    logic [10:0] fd_idx;
    logic [15:0] wait_idx;
    logic [PERS_W-1:0] low_run;
    logic [PERS_W-1:0] high_run;
    logic irq_flag;
    logic low_flag;
    logic high_flag;
    logic sample_tick;
    logic light_done;
    logic fd_done;
    logic fd_end;
    logic [7:0] rdata;
  } lmt_st_t;

  lmt_st_t s;
  lmt_st_t next_s;

  // Counter reaching its programmed terminal value
  function automatic logic hit11(input logic [10:0] cnt, input logic [10:0] lim);
    hit11 = (cnt == lim);
  endfunction

  // Saturating increment of a persistence run
  function automatic logic [PERS_W-1:0] run_inc(input logic [PERS_W-1:0] r);
    run_inc = (&r) ? r : r + 1'b1;
  endfunction

  // Register read decode
  function automatic logic [7:0] rd_mux(input lmt_st_t st, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == lmt_pkg::LMT_ADDR_STEP_LO) begin
      v = st.step[7:0];
    end else if (a == lmt_pkg::LMT_ADDR_STEP_HI) begin
      v = {5'h00, st.step[10:8]};
    end else if (a == lmt_pkg::LMT_ADDR_ALS_LO) begin
      v = st.als_cnt[7:0];
    end else if (a == lmt_pkg::LMT_ADDR_ALS_HI) begin
      v = {5'h00, st.als_cnt[10:8]};
    end else if (a == lmt_pkg::LMT_ADDR_FD_LO) begin
      v = st.fd_cnt[7:0];
    end else if (a == lmt_pkg::LMT_ADDR_FD_HI) begin
      v = {st.endless, 4'h0, st.fd_cnt[10:8]};
    end else if (a == lmt_pkg::LMT_ADDR_WAIT) begin
      v = st.wait_val;
    end else if (a == lmt_pkg::LMT_ADDR_LOW_TH0) begin
      v = st.low_th[7:0];
    end else if (a == lmt_pkg::LMT_ADDR_LOW_TH1) begin
      v = st.low_th[15:8];
    end else if (a == lmt_pkg::LMT_ADDR_LOW_TH2) begin
      v = st.low_th[23:16];
    end else if (a == lmt_pkg::LMT_ADDR_HIGH_TH0) begin
      v = st.high_th[7:0];
    end else if (a == lmt_pkg::LMT_ADDR_HIGH_TH1) begin
      v = st.high_th[15:8];
    end else if (a == lmt_pkg::LMT_ADDR_HIGH_TH2) begin
      v = st.high_th[23:16];
    end else if (a == lmt_pkg::LMT_ADDR_STATUS) begin
      v = 8'h00;
      v[lmt_pkg::LMT_IRQ_FLAG_BIT] = st.irq_flag;
    end
    rd_mux = v;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  logic run;
  logic pre_tick;
  logic mod_tick;
  logic step_end;
  logic meas_end;
  logic [23:0] sel_data;
  logic below;
  logic above;
  logic [PERS_W-1:0] low_next;
  logic [PERS_W-1:0] high_next;
  logic clr_irq;

  always_comb begin
    next_s = s;
    next_s.sample_tick = 1'b0;
    next_s.light_done = 1'b0;
    next_s.fd_done = 1'b0;
    next_s.fd_end = 1'b0;
    run = i_power_on_bit && (i_light_enable || i_flicker_enable);
    pre_tick = 1'b0;
    mod_tick = 1'b0;
    step_end = 1'b0;
    meas_end = 1'b0;
    clr_irq = 1'b0;

    if (i_reg_wr) begin
      if (i_reg_addr == lmt_pkg::LMT_ADDR_STEP_LO) begin
        next_s.step[7:0] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_STEP_HI) begin
        next_s.step[10:8] = i_reg_wdata[lmt_pkg::LMT_HI_FIELD_W-1:0];
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_ALS_LO) begin
        next_s.als_cnt[7:0] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_ALS_HI) begin
        next_s.als_cnt[10:8] = i_reg_wdata[lmt_pkg::LMT_HI_FIELD_W-1:0];
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_FD_LO) begin
        next_s.fd_cnt[7:0] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_FD_HI) begin
        next_s.fd_cnt[10:8] = i_reg_wdata[lmt_pkg::LMT_HI_FIELD_W-1:0];
        next_s.endless = i_reg_wdata[lmt_pkg::LMT_ENDLESS_BIT];
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_WAIT) begin
        next_s.wait_val = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_LOW_TH0) begin
        next_s.low_th[7:0] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_LOW_TH1) begin
        next_s.low_th[15:8] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_LOW_TH2) begin
        next_s.low_th[23:16] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_HIGH_TH0) begin
        next_s.high_th[7:0] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_HIGH_TH1) begin
        next_s.high_th[15:8] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_HIGH_TH2) begin
        next_s.high_th[23:16] = i_reg_wdata;
      end else if (i_reg_addr == lmt_pkg::LMT_ADDR_STATUS) begin
        clr_irq = i_reg_wdata[lmt_pkg::LMT_IRQ_FLAG_BIT];
      end
    end

    // Registered read data, held between reads
    if (i_reg_rd) begin
      next_s.rdata = rd_mux(s, i_reg_addr);
    end

    if (s.pre == 16'(MOD_CYCLES - 1)) begin
      next_s.pre = 16'h0000;
      pre_tick = 1'b1;
    end else begin
      next_s.pre = s.pre + 16'h0001;
    end
    // divide modulator clock by two to the selection
    if (pre_tick) begin
      if (s.div == DIV_W'((DIV_W'(1) << i_modulator_clock_divider) - 1'b1)) begin
        next_s.div = '0;
        mod_tick = 1'b1;
      end else begin
        next_s.div = s.div + 1'b1;
      end
    end

    // step of programmed value plus one
    if (mod_tick && s.state != lmt_pkg::LMT_IDLE) begin
      if (hit11(s.step_idx, s.sh_step)) begin
        next_s.step_idx = 11'h000;
        step_end = 1'b1;
        next_s.sample_tick = 1'b1;
      end else begin
        next_s.step_idx = s.step_idx + 11'h001;
      end
    end

    // Measurement sequencer
    case (s.state)
      lmt_pkg::LMT_IDLE: begin
        next_s.sh_step = s.step;
        next_s.sh_als = s.als_cnt;
        next_s.sh_fd = s.fd_cnt;
        next_s.sh_endless = s.endless;
        // wait is trigger setting times wait value
        next_s.sh_wait = 16'(i_trigger_timing_setting) * 16'(s.wait_val);
        next_s.step_idx = 11'h000;
        next_s.als_idx = 11'h000;
        next_s.fd_idx = 11'h000;
        next_s.wait_idx = 16'h0000;
        if (run) begin
          next_s.state = lmt_pkg::LMT_MEASURE;
        end
      end
      lmt_pkg::LMT_MEASURE: begin
        if (step_end) begin
          // integration of count plus one steps
          if (hit11(s.als_idx, s.sh_als)) begin
            next_s.als_idx = 11'h000;
            next_s.light_done = i_light_enable;
            meas_end = i_light_enable;
          end else begin
            next_s.als_idx = s.als_idx + 11'h001;
          end
          // flicker step of count plus one samples
          if (hit11(s.fd_idx, s.sh_fd)) begin
            next_s.fd_idx = 11'h000;
            next_s.fd_done = i_flicker_enable;
            // endless mode repeats with no end marker
            next_s.fd_end = i_flicker_enable && !s.sh_endless;
            if (!i_light_enable && !s.sh_endless) begin
              meas_end = 1'b1;
            end
          end else begin
            next_s.fd_idx = s.fd_idx + 11'h001;
          end
        end
        if (meas_end) begin
          next_s.state = (s.sh_wait == 16'h0000) ? lmt_pkg::LMT_IDLE : lmt_pkg::LMT_WAIT;
          next_s.wait_idx = 16'h0000;
        end
      end
      lmt_pkg::LMT_WAIT: begin
        if (step_end) begin
          if (s.wait_idx == s.sh_wait - 16'h0001) begin
            next_s.state = lmt_pkg::LMT_IDLE;
          end else begin
            next_s.wait_idx = s.wait_idx + 16'h0001;
          end
        end
      end
      default: begin
        next_s.state = lmt_pkg::LMT_IDLE;
      end
    endcase

    // power off stops every timing counter
    if (!run) begin
      next_s.state = lmt_pkg::LMT_IDLE;
      next_s.pre = 16'h0000;
      next_s.div = '0;
      next_s.step_idx = 11'h000;
      next_s.als_idx = 11'h000;
      next_s.fd_idx = 11'h000;
      next_s.wait_idx = 16'h0000;
      next_s.sample_tick = 1'b0;
      next_s.light_done = 1'b0;
      next_s.fd_done = 1'b0;
      next_s.fd_end = 1'b0;
    end

    sel_data = i_threshold_channel_select ? i_accum_data1 : i_accum_data0;
    below = sel_data < s.low_th;
    above = sel_data > s.high_th;
    low_next = run_inc(s.low_run);
    high_next = run_inc(s.high_run);

    // write one drops flag and pending runs
    if (clr_irq) begin
      next_s.irq_flag = 1'b0;
      next_s.low_flag = 1'b0;
      next_s.high_flag = 1'b0;
      next_s.low_run = '0;
      next_s.high_run = '0;
    end

    // Set wins over a clear in the same cycle
    if (i_accum_valid && i_power_on_bit) begin
      next_s.low_run = below ? low_next : '0;
      next_s.high_run = above ? high_next : '0;
      if (below && i_light_interrupt_enable && low_next >= i_persistence_count) begin
        next_s.low_flag = 1'b1;
        next_s.irq_flag = 1'b1;
      end
      if (above && i_light_interrupt_enable && high_next >= i_persistence_count) begin
        next_s.high_flag = 1'b1;
        next_s.irq_flag = 1'b1;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      // zero reset for counts, wait, thresholds
      s <= '0;
      s.step <= lmt_pkg::LMT_STEP_RESET;
      s.sh_step <= lmt_pkg::LMT_STEP_RESET;
      s.state <= lmt_pkg::LMT_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_reg_rdata = s.rdata;
  assign o_sample_tick = s.sample_tick;
  assign o_light_done = s.light_done;
  assign o_flicker_step_done = s.fd_done;
  assign o_flicker_end_marker = s.fd_end;
  assign o_measuring = (s.state == lmt_pkg::LMT_MEASURE);
  // interrupt pin follows the sticky flag
  assign o_light_irq = s.irq_flag;
  assign o_low_threshold_flag = s.low_flag;
  assign o_high_threshold_flag = s.high_flag;
endmodule
`default_nettype wire

// ---- lmt_timing_properties.sv ----
// Concurrent checks on the ports of the light measurement timing block
`timescale 1ns/10ps
`default_nettype none
module lmt_timing_properties #(
  parameter int MOD_CYCLES = 4,
  parameter int DIV_SEL_W = 3,
  parameter int PERS_W = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_power_on_bit,
  input wire logic i_light_interrupt_enable,
  input wire logic i_accum_valid,
  input wire logic o_sample_tick,
  input wire logic o_light_done,
  input wire logic o_flicker_step_done,
  input wire logic o_flicker_end_marker,
  input wire logic o_measuring,
  input wire logic o_light_irq,
  input wire logic o_low_threshold_flag,
  input wire logic o_high_threshold_flag
);
  // ****************************************
  // Timing and interrupt checks
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic clr_wr;
  // Status write that clears the interrupt
  assign clr_wr = i_reg_wr && (i_reg_addr == lmt_pkg::LMT_ADDR_STATUS)
    && i_reg_wdata[lmt_pkg::LMT_IRQ_FLAG_BIT];
  a_tick_single: assert property (o_sample_tick |=> !o_sample_tick)
    else $error("sample tick wider than one cycle");
  a_als_done_tick: assert property (o_light_done |-> o_sample_tick)
    else $error("light done away from a sample tick");
  a_fd_step_tick: assert property (o_flicker_step_done |-> o_sample_tick)
    else $error("flicker step done away from a sample tick");
  a_marker_with_step: assert property (o_flicker_end_marker |-> o_flicker_step_done)
    else $error("end marker without flicker step end");
  a_power_off_halts: assert property (!i_power_on_bit [*2] |-> !o_measuring && !o_sample_tick)
    else $error("timing runs while powered off");
  a_irq_needs_cause: assert property ($rose(o_light_irq) |->
    $past(i_light_interrupt_enable) && $past(i_accum_valid))
    else $error("interrupt raised without enabled sample");
  a_flag_sets_irq: assert property ($rose(o_low_threshold_flag) || $rose(o_high_threshold_flag)
    |-> o_light_irq)
    else $error("threshold flag without interrupt");
  a_irq_sticky: assert property (o_light_irq && i_power_on_bit && !clr_wr |=> o_light_irq)
    else $error("interrupt dropped without clear");
  a_irq_clear: assert property (clr_wr && !i_accum_valid |=>
    !o_light_irq && !o_low_threshold_flag && !o_high_threshold_flag)
    else $error("interrupt survived clear write");
  c_light_done: cover property (o_light_done);
  c_end_marker: cover property (o_flicker_end_marker);
  c_high_flag: cover property ($rose(o_high_threshold_flag));
endmodule
`default_nettype wire

// ---- lmt_host_model.sv ----
// Host model driving the register port of the timing block
`timescale 1ns/10ps
`default_nettype none
module lmt_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata
);
  // Idle bus at time zero
  initial begin
    o_reg_wr = 1'h0;
    o_reg_rd = 1'h0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  // One write strobe, then address and data scrambled on release
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_core_clk);
    o_reg_wr = 1'h1;
    o_reg_addr = addr;
    o_reg_wdata = data;
    @(negedge i_core_clk);
    o_reg_wr = 1'h0;
    o_reg_addr = ~addr;
    o_reg_wdata = ~data;
  endtask
  // One read strobe, data taken the cycle after
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge i_core_clk);
    o_reg_rd = 1'h1;
    o_reg_addr = addr;
    @(negedge i_core_clk);
    o_reg_rd = 1'h0;
    o_reg_addr = ~addr;
    data = i_reg_rdata;
  endtask
  task automatic clear_irq();
    write_reg(lmt_pkg::LMT_ADDR_STATUS, 8'h08);
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the light measurement timing block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ****************************************
  // Signals, design and host
  // ****************************************
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic reg_wr, reg_rd, power, light_en, fd_en, irq_en, chan, valid;
  logic tick, light_done, fstep_done, end_marker, measuring, irq, low_flag, high_flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, trig, rd;
  logic [2:0] div;
  logic [3:0] pers;
  logic [23:0] data0, data1;
  int err_count = 0;
  int checks_done = 0;
  int t, c;
  logic [23:0] rows [19] = '{24'h84FF07, 24'h840000, 24'h830101, 24'h86FD05, 24'h860000,
    24'h850202, 24'h88FF87, 24'h880101, 24'h870101, 24'h89A5A5, 24'h890000, 24'h8A0000,
    24'h8B0101, 24'h8C0000, 24'h8D0000, 24'h8E0202, 24'h8F0000, 24'h905A00, 24'h930000};
  // Core clock
  always #2.5 clk = ~clk;
  lmt_timing #(.MOD_CYCLES(4)) uut (
    .i_core_clk(clk), .i_rst(rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_power_on_bit(power), .i_light_enable(light_en), .i_flicker_enable(fd_en),
    .i_modulator_clock_divider(div), .i_trigger_timing_setting(trig),
    .i_light_interrupt_enable(irq_en), .i_persistence_count(pers),
    .i_threshold_channel_select(chan), .i_accum_valid(valid), .i_accum_data0(data0),
    .i_accum_data1(data1), .o_sample_tick(tick), .o_light_done(light_done),
    .o_flicker_step_done(fstep_done), .o_flicker_end_marker(end_marker),
    .o_measuring(measuring), .o_light_irq(irq), .o_low_threshold_flag(low_flag),
    .o_high_threshold_flag(high_flag));
  lmt_host_model host (.i_core_clk(clk), .i_reg_rdata(reg_rdata), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Count ticks and cycles up to the selected event
  task automatic wait_for(input int sel, output int ticks, output int cycles);
    logic [3:0] ev;
    ticks = 0;
    cycles = 0;
    do begin
      @(negedge clk);
      ev = {end_marker, fstep_done, light_done, tick};
      cycles++;
      ticks += int'(tick);
    end while (ev[sel] !== 1'h1 && cycles < 3000);
    // Event never came: count it and end the run
    if (cycles >= 3000) begin
      err_count++;
      stop_test();
    end
  endtask
  // One accumulated sample, then the flags
  task automatic pulse(input logic [23:0] d0, input logic [23:0] d1, input logic [2:0] exp);
    @(negedge clk);
    valid = 1'h1;
    data0 = d0;
    data1 = d1;
    @(negedge clk);
    valid = 1'h0;
    data0 = ~d0;
    data1 = ~d1;
    check(16'({irq, low_flag, high_flag}), 16'(exp));
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {power, light_en, fd_en, irq_en, chan, valid} = 6'h00;
    {div, pers, trig} = 15'h0000;
    {data0, data1} = 48'h0;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    for (int a = 8'h83; a <= 8'h8F; a++) begin
      host.read_reg(8'(a), rd);
      check(16'(rd), (a == 8'h83) ? 16'h00B3 : 16'h0000);
    end
    foreach (rows[i]) begin
      host.write_reg(rows[i][23:16], rows[i][15:8]);
      host.read_reg(rows[i][23:16], rd);
      check(16'(rd), 16'(rows[i][7:0]));
    end
    // Step 1, divider 1, three samples per integration
    div = 3'h1;
    light_en = 1'h1;
    power = 1'h1;
    wait_for(1, t, c);
    check(16'(t), 16'h0003);
    wait_for(0, t, c);
    wait_for(0, t, c);
    check(16'(c), 16'h0010);
    trig = 8'h02;
    host.write_reg(8'h89, 8'h01);
    wait_for(1, t, c);
    wait_for(1, t, c);
    check(16'(c), 16'h0030);
    wait_for(1, t, c);
    check(16'(c), 16'h0050);
    check(16'(t), 16'h0005);
    power = 1'h0;
    light_en = 1'h0;
    repeat (2) @(negedge clk);
    check(16'(measuring), 16'h0000);
    // Flicker step of two samples, plain then endless
    for (int e = 0; e < 2; e++) begin
      host.write_reg(8'h88, e ? 8'h80 : 8'h00);
      fd_en = 1'h1;
      power = 1'h1;
      wait_for(2, t, c);
      check(16'(t), 16'h0002);
      check(16'(end_marker), e ? 16'h0000 : 16'h0001);
      power = 1'h0;
    end
    // Thresholds, persistence, enable and clearing
    host.write_reg(8'h89, 8'h00);
    fd_en = 1'h0;
    power = 1'h1;
    irq_en = 1'h1;
    pulse(24'h0001FF, 24'h0, 3'h0);
    pulse(24'h0000FF, 24'h0, 3'h6);
    host.clear_irq();
    host.read_reg(8'h93, rd);
    check(16'({rd, irq}), 16'h0000);
    irq_en = 1'h0;
    pulse(24'h0000FF, 24'h0, 3'h0);
    host.clear_irq();
    irq_en = 1'h1;
    pers = 4'h2;
    pulse(24'h0000FF, 24'h0, 3'h0);
    pulse(24'h0000FF, 24'h0, 3'h6);
    host.clear_irq();
    pers = 4'h0;
    chan = 1'h1;
    pulse(24'h0000FF, 24'h000201, 3'h5);
    host.read_reg(8'h93, rd);
    check(16'(rd), 16'h0008);
    // Clear and a new event in one cycle: the event wins
    fork
      host.clear_irq();
      pulse(24'h0000FF, 24'h000201, 3'h5);
    join
    // Reset with measurement stopped and interrupt and high flag set restores defaults
    rst = 1'h1;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    check(16'({irq, high_flag, measuring}), 16'h0000);
    host.read_reg(8'h83, rd);
    check(16'(rd), 16'h00B3);
    host.read_reg(8'h8E, rd);
    check(16'(rd), 16'h0000);
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule
bind lmt_timing lmt_timing_properties #(.MOD_CYCLES(MOD_CYCLES), .DIV_SEL_W(DIV_SEL_W),
  .PERS_W(PERS_W)) chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_power_on_bit(i_power_on_bit),
  .i_light_interrupt_enable(i_light_interrupt_enable), .i_accum_valid(i_accum_valid),
  .o_sample_tick(o_sample_tick), .o_light_done(o_light_done),
  .o_flicker_step_done(o_flicker_step_done), .o_flicker_end_marker(o_flicker_end_marker),
  .o_measuring(o_measuring), .o_light_irq(o_light_irq),
  .o_low_threshold_flag(o_low_threshold_flag), .o_high_threshold_flag(o_high_threshold_flag));
`default_nettype wire
